// >>> include/cff_pkg.sv
package cff_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_FF_VOLT = 8'h00;
	localparam logic [7:0] ADDR_FF_ACC = 8'h04;
	localparam logic [7:0] ADDR_FF_VEL = 8'h08;
	localparam logic [7:0] ADDR_SUBMODE = 8'h0c;
	localparam logic [7:0] ADDR_OPMODE = 8'h10;
	localparam logic [7:0] ADDR_FB_MASK = 8'h14;
	localparam logic [7:0] ADDR_ACC_SCALE = 8'h18;
	localparam logic [7:0] ADDR_LIM_SPEED = 8'h1c;
	localparam logic [7:0] ADDR_LIM_CUR = 8'h20;
	localparam logic [7:0] ADDR_LIM_PWM = 8'h24;
	localparam logic [7:0] ADDR_KP = 8'h28;
	localparam logic [7:0] ADDR_TI_POS = 8'h2c;
	localparam logic [7:0] ADDR_TI_VEL = 8'h30;
	localparam logic [7:0] ADDR_TI_CUR = 8'h34;
	localparam logic [7:0] ADDR_SENS_ABS = 8'h38;
	localparam logic [7:0] ADDR_STATUS = 8'h3c;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] RST_FF_VOLT = 16'h03e8;
	localparam logic [15:0] RST_FF_ACC = 16'h0000;
	localparam logic [15:0] RST_FF_VEL = 16'h0000;
	localparam logic [15:0] RST_ACC_SCALE = 16'h03e8;
	localparam logic [7:0] RST_SUBMODE = 8'h00;
	localparam logic [7:0] RST_OPMODE = 8'h01;
	localparam logic [11:0] RST_FB_MASK = 12'h000;
	localparam logic [14:0] RST_LIM = 15'h7fff;
	localparam logic [23:0] RST_KP = 24'h101010;
	localparam logic [15:0] RST_TI = 16'h0000;
	localparam logic [3:0] RST_SENS_ABS = 4'h0;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SUB_CL_EN = 0;
	localparam int SUB_POS_VEL = 1;
	localparam int SUB_ALIGN = 4;
	localparam int SUB_REAL_TQ = 5;
	localparam int MASK_POS = 0;
	localparam int MASK_VEL = 1;
	localparam int MASK_COMM = 2;
	localparam int NSENS = 4;
	localparam int STAT_IDX = 0;
	localparam int STAT_ALIGN = 4;
	localparam int STAT_COMM = 8;
	localparam int STAT_POS = 10;
	localparam int STAT_VEL = 12;
	localparam int STAT_CL = 15;
	// ----------------------------------------
	// Arithmetic constants and modes
	// ----------------------------------------
	localparam logic signed [39:0] FF_DIV = 40'sh00000003e8;
	localparam logic [14:0] FULL = 15'h7fff;
	localparam int PI_KP_SHIFT = 4;
	localparam int PI_INT_SHIFT = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] MODE_PP = 8'h01;
	localparam logic [7:0] MODE_VL = 8'h02;
	localparam logic [7:0] MODE_PV = 8'h03;
	localparam logic [7:0] MODE_TQ = 8'h04;
	localparam logic [7:0] MODE_HM = 8'h06;
	localparam logic [7:0] MODE_IP = 8'h07;
	localparam logic [7:0] MODE_CSP = 8'h08;
	localparam logic [7:0] MODE_CSV = 8'h09;
	localparam logic [7:0] MODE_CST = 8'h0a;
	localparam logic [7:0] MODE_CLKDIR = 8'hff;

	typedef enum logic [1:0] {AL_IDLE, AL_MOVE, AL_DONE} cff_align_t;

	function automatic logic signed [15:0] cff_sat(input logic signed [39:0] v,
		input logic [14:0] lim);
		logic signed [39:0] hi;
		logic signed [39:0] lo;
		hi = $signed({25'h0000000, lim});
		lo = -hi;
		if (v > hi)
			return hi[15:0];
		else if (v < lo)
			return lo[15:0];
		return v[15:0];
	endfunction : cff_sat

	function automatic logic [3:0] cff_col(input logic [11:0] m, input int f);
		logic [3:0] r;
		for (int i = 0; i < NSENS; i++)
			r[i] = m[i * 3 + f];
		return r;
	endfunction : cff_col

	// Scan from sensor one upward; sensorless is the fallback
	function automatic logic [1:0] cff_first(input logic [3:0] b);
		logic [1:0] r;
		r = 2'h0;
		for (int i = NSENS - 1; i >= 1; i--)
			if (b[i])
				r = 2'(i);
		return r;
	endfunction : cff_first

	function automatic logic [31:0] cff_merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[b * 8 +: 8] = d[b * 8 +: 8];
		return r;
	endfunction : cff_merge
endpackage : cff_pkg

// >>> verilog/cff_scale.sv
`timescale 1ns/1ns
`default_nettype none
module cff_scale
	import cff_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic signed [15:0] x,
	input wire logic [15:0] f,
	output logic signed [15:0] y
);
	logic signed [39:0] prod;

	assign prod = 40'(x) * $signed({24'h000000, f});

	// Saturate rather than wrap when the factor exceeds full scale
	always_ff @(posedge clk) begin
		if (sys_rst)
			y <= 16'sh0000;
		else
			y <= cff_sat(prod / FF_DIV, FULL);
	end
endmodule : cff_scale
`default_nettype wire

// >>> verilog/cff_pi.sv
`timescale 1ns/1ns
`default_nettype none
module cff_pi
	import cff_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic run,
	input wire logic signed [15:0] err,
	input wire logic [7:0] kp,
	input wire logic [15:0] ti,
	input wire logic [14:0] lim,
	output logic signed [15:0] out
);
	logic signed [39:0] integ;
	logic signed [39:0] ilim;
	logic signed [39:0] isum;
	logic signed [39:0] pterm;

	assign ilim = $signed({17'h00000, lim, 8'h00});
	assign isum = integ + 40'(err);
	assign pterm = (40'(err) * $signed({32'h00000000, kp})) >>> PI_KP_SHIFT;

	// Clamp the integrator too, so it cannot wind up past the limit
	always_ff @(posedge clk) begin
		if (sys_rst || !run || ti == 16'h0000)
			integ <= 40'sh0000000000;
		else if (isum > ilim)
			integ <= ilim;
		else if (isum < -ilim)
			integ <= -ilim;
		else
			integ <= isum;
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !run)
			out <= 16'sh0000;
		else
			out <= cff_sat(pterm + (integ >>> PI_INT_SHIFT), lim);
	end
endmodule : cff_pi
`default_nettype wire

// >>> verilog/cff_top.sv
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Velocity feed-forward: ramp velocity times factor/1000 added after position loop.
// - Velocity feed-forward only in position-loop modes, velocity modes with submode bit 1.
// - Acceleration feed-forward: ramp accel times scale times factor, before current loop.
// - Acceleration feed-forward omitted in torque modes.
// - Voltage feed-forward is factor per mille of rated-current voltage; resets full.
// - Voltage feed-forward in all modes; factor zero removes it.
// - Mask bit 0 position, bit 1 velocity, bit 2 commutation.
// - Mask entry zero is the sensorless observer; others follow sensor order.
// - Each loop takes the first flagged sensor scanning upward from sensor one.
// - Among commutation sensors, use the first one currently aligned.
// - No aligned commutation sensor: align in open loop regardless of submode bit 4.
// - Closed loop needs submode bit 0; auto setup success sets it.
// - Absolute commutation sensor gives closed loop right from power-up.
// - Incremental encoder commutation stays open loop until its index is seen or auto alignment is done.
// - Auto alignment once per restart at first enable command, then continue.
// - Status bit 15 shows closed loop while operation is enabled.
// - Integrator time zero forces the integral term to zero.
// - Loop outputs limited to max speed, max current, max PWM.
module cff_top
	import cff_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic signed [15:0] ramp_pos,
	input wire logic signed [15:0] ramp_vel,
	input wire logic signed [15:0] ramp_acc,
	input wire logic signed [15:0] target_torque,
	input wire logic [63:0] sens_pos,
	input wire logic [63:0] sens_vel,
	input wire logic [63:0] sens_angle,
	input wire logic signed [15:0] cur_actual,
	input wire logic [15:0] open_angle,
	input wire logic [3:0] enc_index_pin,
	input wire logic align_ack_pin,
	input wire logic op_enable_cmd,
	input wire logic op_enabled,
	input wire logic auto_setup_ok,
	output logic signed [15:0] vel_cmd,
	output logic signed [15:0] cur_cmd,
	output logic signed [15:0] pwm_cmd,
	output logic [15:0] comm_angle,
	output logic [1:0] comm_src,
	output logic closed_loop,
	output logic status_cl,
	output logic align_req,
	output logic op_enable_ok
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [15:0] ff_volt, ff_acc, ff_vel, acc_scale;
	logic [7:0] submode, op_mode;
	logic [11:0] fb_mask;
	logic [14:0] lim_speed, lim_cur, lim_pwm;
	logic [23:0] kp_all;
	logic [15:0] ti_pos, ti_vel, ti_cur;
	logic [3:0] sens_abs;
	logic [7:0] waddr;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;
	logic [32:0] wr_old;
	logic [32:0] rd_word;
	logic [31:0] wmerge;
	logic [3:0] idx_s1, idx_s2, idx_seen;
	logic ack_s1, ack_s2;
	cff_align_t al_state, next_al_state;
	logic [1:0] pos_sel, vel_sel;
	logic [3:0] aligned, comm_bits;
	logic comm_ok, pos_on, torque_on;
	logic signed [15:0] pos_err, vel_err, cur_err;
	logic signed [15:0] pos_out, vel_out, cur_out;
	logic signed [15:0] vel_ff, acc_ff1, acc_ff2, volt_ff;
	logic signed [15:0] vel_term, acc_term, volt_term;

	function automatic logic [32:0] reg_word(input logic [7:0] a);
		logic [31:0] w;
		logic hit;
		w = 32'h00000000;
		hit = 1'b1;
		case (a)
			ADDR_FF_VOLT: w[15:0] = ff_volt;
			ADDR_FF_ACC: w[15:0] = ff_acc;
			ADDR_FF_VEL: w[15:0] = ff_vel;
			ADDR_SUBMODE: w[7:0] = submode;
			ADDR_OPMODE: w[7:0] = op_mode;
			ADDR_FB_MASK: w[11:0] = fb_mask;
			ADDR_ACC_SCALE: w[15:0] = acc_scale;
			ADDR_LIM_SPEED: w[14:0] = lim_speed;
			ADDR_LIM_CUR: w[14:0] = lim_cur;
			ADDR_LIM_PWM: w[14:0] = lim_pwm;
			ADDR_KP: w[23:0] = kp_all;
			ADDR_TI_POS: w[15:0] = ti_pos;
			ADDR_TI_VEL: w[15:0] = ti_vel;
			ADDR_TI_CUR: w[15:0] = ti_cur;
			ADDR_SENS_ABS: w[3:0] = sens_abs;
			ADDR_STATUS: begin
				w[STAT_IDX +: 4] = idx_seen;
				w[STAT_ALIGN] = (al_state == AL_DONE);
				w[STAT_COMM +: 2] = comm_src;
				w[STAT_POS +: 2] = pos_sel;
				w[STAT_VEL +: 2] = vel_sel;
				w[STAT_CL] = status_cl;
			end
			default: hit = 1'b0;
		endcase
		return {hit, w};
	endfunction : reg_word

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	// Ready flags double as "slot empty"; the write fires once both halves are held
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	// Processes, not assigns, so a change of register contents reruns the lookup
	always_comb wr_old = reg_word(waddr);
	always_comb rd_word = reg_word(s_axi_araddr);
	assign wmerge = cff_merge(wr_old[31:0], wdata_q, wstrb_q);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			waddr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			waddr <= s_axi_awaddr;
		end else if (do_write)
			s_axi_awready <= 1'b1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_wready <= 1'b1;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (do_write)
			s_axi_wready <= 1'b1;
	end

	// Status is read-only, so a write to it is refused
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_old[32] && waddr != ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word[31:0];
			s_axi_rresp <= rd_word[32] ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ff_volt <= RST_FF_VOLT;
			ff_acc <= RST_FF_ACC;
			ff_vel <= RST_FF_VEL;
			acc_scale <= RST_ACC_SCALE;
			submode <= RST_SUBMODE;
			op_mode <= RST_OPMODE;
			fb_mask <= RST_FB_MASK;
			lim_speed <= RST_LIM;
			lim_cur <= RST_LIM;
			lim_pwm <= RST_LIM;
			kp_all <= RST_KP;
			ti_pos <= RST_TI;
			ti_vel <= RST_TI;
			ti_cur <= RST_TI;
			sens_abs <= RST_SENS_ABS;
		end else begin
			if (do_write) begin
				case (waddr)
					ADDR_FF_VOLT: ff_volt <= wmerge[15:0];
					ADDR_FF_ACC: ff_acc <= wmerge[15:0];
					ADDR_FF_VEL: ff_vel <= wmerge[15:0];
					ADDR_SUBMODE: submode <= wmerge[7:0];
					ADDR_OPMODE: op_mode <= wmerge[7:0];
					ADDR_FB_MASK: fb_mask <= wmerge[11:0];
					ADDR_ACC_SCALE: acc_scale <= wmerge[15:0];
					ADDR_LIM_SPEED: lim_speed <= wmerge[14:0];
					ADDR_LIM_CUR: lim_cur <= wmerge[14:0];
					ADDR_LIM_PWM: lim_pwm <= wmerge[14:0];
					ADDR_KP: kp_all <= wmerge[23:0];
					ADDR_TI_POS: ti_pos <= wmerge[15:0];
					ADDR_TI_VEL: ti_vel <= wmerge[15:0];
					ADDR_TI_CUR: ti_cur <= wmerge[15:0];
					ADDR_SENS_ABS: sens_abs <= wmerge[3:0];
					default: ;
				endcase
			end
			// Setup success overrides a same-cycle software clear
			if (auto_setup_ok)
				submode[SUB_CL_EN] <= 1'b1;
		end
	end

	// ----------------------------------------
	// Pin synchronisers and index memory
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			idx_s1 <= 4'h0;
			idx_s2 <= 4'h0;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			idx_s1 <= enc_index_pin;
			idx_s2 <= idx_s1;
			ack_s1 <= align_ack_pin;
			ack_s2 <= ack_s1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			idx_seen <= 4'h0;
		else
			idx_seen <= idx_seen | idx_s2;
	end

	// ----------------------------------------
	// Feedback selection and commutation
	// ----------------------------------------
	assign comm_bits = cff_col(fb_mask, MASK_COMM);
	assign aligned = sens_abs | idx_seen;
	assign comm_ok = |(comm_bits[3:1] & aligned[3:1]);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pos_sel <= 2'h0;
			vel_sel <= 2'h0;
			comm_src <= 2'h0;
		end else begin
			pos_sel <= cff_first(cff_col(fb_mask, MASK_POS));
			vel_sel <= cff_first(cff_col(fb_mask, MASK_VEL));
			comm_src <= comm_ok ? cff_first(comm_bits & aligned) : cff_first(comm_bits);
		end
	end

	// Brake control is assumed released by the outside party before alignment
	always_comb begin
		next_al_state = al_state;
		unique case (al_state)
			AL_IDLE:
				if (op_enable_cmd && submode[SUB_CL_EN] && (submode[SUB_ALIGN] || !comm_ok))
					next_al_state = AL_MOVE;
			AL_MOVE:
				if (ack_s2)
					next_al_state = AL_DONE;
			AL_DONE: next_al_state = AL_DONE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			al_state <= AL_IDLE;
			align_req <= 1'b0;
			op_enable_ok <= 1'b1;
		end else begin
			al_state <= next_al_state;
			align_req <= (next_al_state == AL_MOVE);
			op_enable_ok <= (next_al_state != AL_MOVE);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			closed_loop <= 1'b0;
			status_cl <= 1'b0;
			comm_angle <= 16'h0000;
		end else begin
			closed_loop <= submode[SUB_CL_EN] && (comm_ok || al_state == AL_DONE);
			status_cl <= closed_loop && op_enabled;
			comm_angle <= closed_loop ? sens_angle[{comm_src, 4'h0} +: 16] : open_angle;
		end
	end

	// ----------------------------------------
	// Loop cascade with feed-forward
	// ----------------------------------------
	assign pos_on = (op_mode == MODE_PP) || (op_mode == MODE_HM) || (op_mode == MODE_IP) ||
		(op_mode == MODE_CSP) || (op_mode == MODE_CLKDIR) ||
		(submode[SUB_POS_VEL] && (op_mode == MODE_VL || op_mode == MODE_PV ||
		op_mode == MODE_CSV));
	assign torque_on = (op_mode == MODE_TQ) || (op_mode == MODE_CST);

	cff_scale u_vff (.clk(clk), .sys_rst(sys_rst), .x(ramp_vel), .f(ff_vel), .y(vel_ff));
	cff_scale u_aff1 (.clk(clk), .sys_rst(sys_rst), .x(ramp_acc), .f(acc_scale), .y(acc_ff1));
	cff_scale u_aff2 (.clk(clk), .sys_rst(sys_rst), .x(acc_ff1), .f(ff_acc), .y(acc_ff2));
	cff_scale u_uff (.clk(clk), .sys_rst(sys_rst), .x(cur_cmd), .f(ff_volt), .y(volt_ff));

	cff_pi u_pos (.clk(clk), .sys_rst(sys_rst), .run(pos_on), .err(pos_err),
		.kp(kp_all[7:0]), .ti(ti_pos), .lim(lim_speed), .out(pos_out));
	cff_pi u_vel (.clk(clk), .sys_rst(sys_rst),
		.run(!(torque_on && submode[SUB_REAL_TQ])), .err(vel_err),
		.kp(kp_all[15:8]), .ti(ti_vel), .lim(lim_cur), .out(vel_out));
	cff_pi u_cur (.clk(clk), .sys_rst(sys_rst), .run(1'b1), .err(cur_err),
		.kp(kp_all[23:16]), .ti(ti_cur), .lim(lim_pwm), .out(cur_out));

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			vel_term <= 16'sh0000;
			acc_term <= 16'sh0000;
			volt_term <= 16'sh0000;
		end else begin
			vel_term <= pos_on ? vel_ff : 16'sh0000;
			acc_term <= torque_on ? 16'sh0000 : acc_ff2;
			volt_term <= (ff_volt == 16'h0000) ? 16'sh0000 : volt_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pos_err <= 16'sh0000;
			vel_err <= 16'sh0000;
			cur_err <= 16'sh0000;
			vel_cmd <= 16'sh0000;
			cur_cmd <= 16'sh0000;
			pwm_cmd <= 16'sh0000;
		end else begin
			pos_err <= cff_sat(40'(ramp_pos) - 40'($signed(sens_pos[{pos_sel, 4'h0} +: 16])), FULL);
			vel_err <= cff_sat(40'(vel_cmd) - 40'($signed(sens_vel[{vel_sel, 4'h0} +: 16])), FULL);
			cur_err <= cff_sat(40'(cur_cmd) - 40'(cur_actual), FULL);
			vel_cmd <= pos_on ? cff_sat(40'(pos_out) + 40'(vel_term), lim_speed)
				: cff_sat(40'(ramp_vel), lim_speed);
			cur_cmd <= (torque_on && submode[SUB_REAL_TQ]) ? cff_sat(40'(target_torque), lim_cur)
				: cff_sat(40'(vel_out) + 40'(acc_term), lim_cur);
			pwm_cmd <= cff_sat(40'(cur_out) + 40'(volt_term), lim_pwm);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Output was clamped with the limit of the previous edge
	speed_limit_a: assert property (##1 (
		$signed(vel_cmd) <= $signed({1'b0, $past(lim_speed)}) &&
		$signed(vel_cmd) >= -$signed({1'b0, $past(lim_speed)})))
		else $error("velocity command beyond speed limit");
	pwm_limit_a: assert property (##1 ($signed(pwm_cmd) <= $signed({1'b0, $past(lim_pwm)})))
		else $error("pwm command beyond pwm limit");
	volt_off_a: assert property (ff_volt == 16'h0000 |=> volt_term == 16'sh0000)
		else $error("voltage feed-forward not removed at factor zero");
	acc_torque_a: assert property (torque_on |=> acc_term == 16'sh0000)
		else $error("acceleration feed-forward in torque mode");
	vel_mode_a: assert property (!pos_on |=> vel_term == 16'sh0000)
		else $error("velocity feed-forward outside position-loop mode");
	cl_gate_a: assert property (!submode[SUB_CL_EN] |=> !closed_loop)
		else $error("closed loop without enable bit");
	abs_cl_a: assert property (submode[SUB_CL_EN] && |(comm_bits[3:1] & sens_abs[3:1])
		|=> closed_loop)
		else $error("absolute commutation sensor did not give closed loop");
	enc_open_a: assert property (!comm_ok && al_state != AL_DONE |=> !closed_loop)
		else $error("closed loop before alignment");
	idx_sticky_a: assert property ((idx_seen & $past(idx_seen)) == $past(idx_seen))
		else $error("index flag lost before restart");
	align_once_a: assert property (al_state == AL_DONE |=> al_state == AL_DONE ##1
		!align_req)
		else $error("alignment repeated after completion");
	status_cl_a: assert property (status_cl |-> $past(op_enabled) && $past(closed_loop))
		else $error("closed loop status outside operation enabled");
	wr_resp_a: assert property (do_write |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write response missing");
endmodule : cff_top
`default_nettype wire

// >>> testbench/cff_plant.sv
`timescale 1ns/1ns
`default_nettype none
module cff_plant #(
	parameter int ACK_DLY = 6
) (
	input wire logic clk,
	input wire logic align_req,
	input wire logic [3:0] idx_req,
	output logic [63:0] sens_pos,
	output logic [63:0] sens_vel,
	output logic [63:0] sens_angle,
	output logic [3:0] enc_index_pin,
	output logic align_ack_pin = 1'b0
);
	int cnt = 0;
	// Rotor held still so position and velocity feedback stay zero
	assign sens_pos = 64'h0;
	assign sens_vel = 64'h0;
	assign sens_angle = 64'h4000_3000_2000_1000;
	assign enc_index_pin = idx_req;
	// No brake control here, so the alignment move is free to turn the rotor
	always @(posedge clk) begin
		cnt <= align_req ? cnt + 1 : 0;
		align_ack_pin <= align_req && cnt >= ACK_DLY;
	end
endmodule : cff_plant
`default_nettype wire

// >>> testbench/test_cff_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_cff_top;
	import cff_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, comm_src;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic signed [15:0] ramp_vel = 16'sh0, ramp_acc = 16'sh0, vel_cmd, cur_cmd, pwm_cmd;
	logic [3:0] idx_req = 4'h0, enc_index_pin;
	logic op_enable_cmd = 1'b0, op_enabled = 1'b0, auto_setup_ok = 1'b0;
	logic [63:0] sens_pos, sens_vel, sens_angle;
	logic align_ack_pin, closed_loop, status_cl, align_req, op_enable_ok, pm;
	logic [15:0] comm_angle;
	logic [7:0] md [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'hff};
	int fail_count = 0, n_checks = 0, i;
	always #20 clk = ~clk;
	cff_top u_cff_top (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ramp_pos(16'sh0),
		.ramp_vel, .ramp_acc, .target_torque(16'sh12c), .sens_pos, .sens_vel, .sens_angle,
		.cur_actual(16'sh0), .open_angle(16'h0), .enc_index_pin, .align_ack_pin,
		.op_enable_cmd, .op_enabled, .auto_setup_ok, .vel_cmd, .cur_cmd, .pwm_cmd,
		.comm_angle, .comm_src, .closed_loop, .status_cl, .align_req, .op_enable_ok);
	cff_plant u_cff_plant (.clk, .align_req, .idx_req, .sens_pos, .sens_vel, .sens_angle,
		.enc_index_pin, .align_ack_pin);
	// ----------------------------------------
	// Bench tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		if (fail_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic guard(input int k);
		if (k >= 50) begin
			fail_count++;
			end_sim();
		end
	endtask : guard
	task automatic restart;
		sys_rst <= 1'b1;
		cyc(8);
		sys_rst <= 1'b0;
		@(posedge clk);
	endtask : restart
	// Address and data are offered together; each is dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'b0;
		guard(i);
		chk(32'(s_axi_bresp), 32'(r));
		// Idle edge so the next call never reassigns a handshake in this time step
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		s_axi_rready <= 1'b0;
		guard(i);
		chk(s_axi_rdata, exp);
		chk(32'(s_axi_rresp), 32'(r));
		@(posedge clk);
	endtask : rd
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		restart();
		rd(ADDR_FF_VOLT, 32'h3e8, RESP_OKAY);
		rd(8'h40, 32'h0, RESP_SLVERR);
		wr(ADDR_STATUS, 32'h0, RESP_SLVERR);
		wr(ADDR_FB_MASK, 32'hccf, RESP_OKAY);
		rd(ADDR_STATUS, 32'h2700, RESP_OKAY);
		// Gains zero: only feed-forward reaches the outputs
		wr(ADDR_KP, 32'h0, RESP_OKAY);
		wr(ADDR_FF_VEL, 32'h1f4, RESP_OKAY);
		wr(ADDR_FF_ACC, 32'hfa, RESP_OKAY);
		ramp_vel <= 16'sh3e8;
		ramp_acc <= 16'sh7d0;
		wr(ADDR_LIM_SPEED, 32'h12c, RESP_OKAY);
		cyc(6);
		chk(32'(vel_cmd), 32'h12c);
		wr(ADDR_LIM_SPEED, 32'h7fff, RESP_OKAY);
		// Third pass: real torque, target passes straight to the current loop
		for (int b = 0; b < 3; b++) begin
			wr(ADDR_SUBMODE, b == 2 ? 32'h20 : 32'(b * 2), RESP_OKAY);
			foreach (md[k]) begin
				wr(ADDR_OPMODE, {24'h0, md[k]}, RESP_OKAY);
				cyc(6);
				pm = md[k] inside {8'h01, 8'h06, 8'h07, 8'h08, 8'hff};
				if (pm || (b == 1 && md[k] inside {8'h02, 8'h03, 8'h09}))
					chk(32'(vel_cmd), 32'h1f4);
				chk(32'(cur_cmd), !(md[k] inside {8'h04, 8'h0a}) ? 32'h1f4
					: (b == 2 ? 32'h12c : 32'h0));
			end
		end
		wr(ADDR_OPMODE, 32'h1, RESP_OKAY);
		cyc(6);
		chk(32'(pwm_cmd), 32'h1f4);
		wr(ADDR_FF_VOLT, 32'h0, RESP_OKAY);
		cyc(6);
		chk(32'(pwm_cmd), 32'h0);
		// Absolute sensor two until the index of sensor one is seen
		wr(ADDR_SENS_ABS, 32'h4, RESP_OKAY);
		wr(ADDR_FB_MASK, 32'h120, RESP_OKAY);
		wr(ADDR_SUBMODE, 32'h1, RESP_OKAY);
		cyc(6);
		chk(32'({closed_loop, comm_src, comm_angle}), 32'({1'b1, 2'h2, 16'h3000}));
		idx_req <= 4'h2;
		cyc(4);
		idx_req <= 4'h0;
		cyc(8);
		chk(32'({closed_loop, comm_src, comm_angle}), 32'({1'b1, 2'h1, 16'h2000}));
		wr(ADDR_SUBMODE, 32'h0, RESP_OKAY);
		cyc(4);
		chk(32'(closed_loop), 32'h0);
		op_enabled <= 1'b1;
		wr(ADDR_SUBMODE, 32'h1, RESP_OKAY);
		cyc(4);
		chk(32'(status_cl), 32'h1);
		rd(ADDR_STATUS, 32'h8102, RESP_OKAY);
		// Restart forgets the index; alignment is forced with no aligned sensor
		restart();
		auto_setup_ok <= 1'b1;
		@(posedge clk);
		auto_setup_ok <= 1'b0;
		rd(ADDR_SUBMODE, 32'h1, RESP_OKAY);
		wr(ADDR_FB_MASK, 32'h20, RESP_OKAY);
		cyc(8);
		chk(32'(closed_loop), 32'h0);
		for (int n = 0; n < 2; n++) begin
			op_enable_cmd <= 1'b1;
			@(posedge clk);
			op_enable_cmd <= 1'b0;
			@(posedge clk);
			chk(32'({align_req, op_enable_ok}), n == 0 ? 32'h2 : 32'h1);
			for (i = 0; i < 50 && align_req; i++)
				@(posedge clk);
			guard(i);
			cyc(3);
			chk(32'({closed_loop, op_enable_ok}), 32'h3);
		end
		rd(ADDR_STATUS, 32'h8110, RESP_OKAY);
		end_sim();
	end
endmodule : test_cff_top
`default_nettype wire
